// ===== vcx_codec.sv
// Overview of operation
// R1: separate converter clocks, independent rates
// R2: converted sample is 8-bit straight binary
// R3: zero input gives 00, reference gives FF
// R4: sample appears one converter clock later
// R5: 10-bit straight binary word, bit 9 MSB
// R6: word captured on converter clock edge
// R7: select low converter, high external feed
// R8: key high connects input to clamp level
// R9: modes none, negative peak, keyed clamp
// R10: unused word inputs tied low outside
// R11: registers update once per converter clock; DAC_OUT, DAC_SRC_EXT, CLAMP_SW, offset and neg_peak load every core clock
module vcx_codec
(
	// core clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// converter clocks, sampled as ordinary inputs
	input wire logic ADC_CLK,
	input wire logic DAC_CLK,
	// analog side, modelled as codes; 255 equals the reference
	input wire vcx_pkg::vcx_ain_t AIN,
	input wire vcx_pkg::vcx_clamp_t CLAMP_MODE,
	// word to convert, external feed and source select
	input wire vcx_pkg::vcx_dac_in_t DAC_IN,
	// converted sample
	output logic [vcx_pkg::ADC_BITS-1:0] ADC_DATA,
	// analog output level and its source
	output logic [vcx_pkg::DAC_BITS-1:0] DAC_OUT,
	output logic DAC_SRC_EXT,
	// clamp switch state
	output logic CLAMP_SW
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_n;
	logic rst_n;

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ----------------------------------------------------------------
	// converter clock edges
	// ----------------------------------------------------------------
	logic adc_clk_q;
	logic dac_clk_q;
	wire adc_edge;
	wire dac_edge;

	// R1: independent edges
	assign adc_edge = ADC_CLK & ~adc_clk_q;
	assign dac_edge = DAC_CLK & ~dac_clk_q;

	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			adc_clk_q <= 1'b0;
			dac_clk_q <= 1'b0;
		end
		else
		begin
			adc_clk_q <= ADC_CLK;
			dac_clk_q <= DAC_CLK;
		end
	end

	// ----------------------------------------------------------------
	// input conditioning
	// ----------------------------------------------------------------
	function automatic logic [vcx_pkg::OFS_BITS-1:0] vcx_diff
	(
		input logic [vcx_pkg::AIN_BITS-1:0] a,
		input logic [vcx_pkg::AIN_BITS-1:0] b
	);
		vcx_diff = {1'b0, a} - {1'b0, b};
	endfunction : vcx_diff

	function automatic logic [vcx_pkg::ADC_BITS-1:0] vcx_quant
	(
		input logic [vcx_pkg::OFS_BITS:0] v
	);
		// negative saturates to zero, at or above reference to full scale
		if (v[vcx_pkg::OFS_BITS])
			vcx_quant = vcx_pkg::ADC_CODE_ZERO;
		else if (|v[vcx_pkg::OFS_BITS-1:vcx_pkg::ADC_BITS])
			vcx_quant = vcx_pkg::ADC_CODE_FULL;
		else
			vcx_quant = v[vcx_pkg::ADC_BITS-1:0];
	endfunction : vcx_quant

	logic [vcx_pkg::OFS_BITS-1:0] offset;
	logic [vcx_pkg::AIN_BITS-1:0] neg_peak;
	logic [vcx_pkg::OFS_BITS-1:0] next_offset;
	logic [vcx_pkg::AIN_BITS-1:0] next_neg_peak;
	wire [vcx_pkg::OFS_BITS:0] shifted;
	wire key_closed;
	wire peak_lower;

	// R8: switch closes only in keyed mode while the key is high
	assign key_closed = (CLAMP_MODE == vcx_pkg::VCX_CLAMP_KEYED) & AIN.key;
	assign peak_lower = AIN.level < neg_peak;
	assign shifted = {1'b0, AIN.level} + {offset[vcx_pkg::OFS_BITS-1], offset};

	always_comb
	begin
		next_offset = offset;
		next_neg_peak = neg_peak;
		case (CLAMP_MODE)
			vcx_pkg::VCX_CLAMP_NONE:
			begin
				next_offset = vcx_pkg::OFS_RESET;
				next_neg_peak = vcx_pkg::PEAK_RESET;
			end
			// R9: follow the negative peak down to the clamp level
			vcx_pkg::VCX_CLAMP_PEAK:
			begin
				if (peak_lower)
				begin
					next_neg_peak = AIN.level;
					next_offset = vcx_diff(AIN.clamp_level, AIN.level);
				end
			end
			// R8: recharge the coupling offset while keyed
			vcx_pkg::VCX_CLAMP_KEYED:
			begin
				next_neg_peak = vcx_pkg::PEAK_RESET;
				if (key_closed)
					next_offset = vcx_diff(AIN.clamp_level, AIN.level);
			end
			default:
			begin
				next_offset = vcx_pkg::OFS_RESET;
				next_neg_peak = vcx_pkg::PEAK_RESET;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			offset <= vcx_pkg::OFS_RESET;
			neg_peak <= vcx_pkg::PEAK_RESET;
			CLAMP_SW <= 1'b0;
		end
		else
		begin
			offset <= next_offset;
			neg_peak <= next_neg_peak;
			CLAMP_SW <= key_closed;
		end
	end

	// ----------------------------------------------------------------
	// analog-to-digital path
	// ----------------------------------------------------------------
	logic [vcx_pkg::ADC_BITS-1:0] adc_stage;
	wire [vcx_pkg::ADC_BITS-1:0] adc_code;

	// R3: straight binary, saturating at both ends
	assign adc_code = key_closed ? vcx_quant({2'b00, AIN.clamp_level}) : vcx_quant(shifted);

	// R11: one update per converter edge
	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			adc_stage <= vcx_pkg::ADC_CODE_ZERO;
			ADC_DATA <= vcx_pkg::ADC_CODE_ZERO;
		end
		// R4: sample on one edge, present on the next
		else if (adc_edge)
		begin
			adc_stage <= adc_code;
			// R2: bit 7 is the most significant bit
			ADC_DATA <= adc_stage;
		end
	end

	// ----------------------------------------------------------------
	// digital-to-analog path
	// ----------------------------------------------------------------
	logic [vcx_pkg::DAC_BITS-1:0] dac_word;
	wire [vcx_pkg::DAC_BITS-1:0] out_sel;

	// R7: select chooses converter or feed-in
	assign out_sel = DAC_IN.use_feed ? DAC_IN.feed : dac_word;

	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dac_word <= vcx_pkg::DAC_RESET;
			DAC_OUT <= vcx_pkg::DAC_RESET;
			DAC_SRC_EXT <= 1'b0;
		end
		else
		begin
			// R6: capture word on converter clock; R5 bit 9 MSB
			if (dac_edge)
				dac_word <= DAC_IN.word;
			DAC_OUT <= out_sel;
			DAC_SRC_EXT <= DAC_IN.use_feed;
		end
	end

endmodule : vcx_codec

// ===== vcx_pkg.sv
package vcx_pkg;

	// ----------------------------------------------------------------
	// widths and code limits
	// ----------------------------------------------------------------
	localparam int ADC_BITS = 8;
	localparam int DAC_BITS = 10;
	localparam int AIN_BITS = 10;
	localparam int OFS_BITS = 11;
	localparam logic [ADC_BITS-1:0] ADC_CODE_ZERO = 8'h00;
	localparam logic [ADC_BITS-1:0] ADC_CODE_FULL = 8'hFF;
	localparam logic [DAC_BITS-1:0] DAC_RESET = 10'h000;
	localparam logic [OFS_BITS-1:0] OFS_RESET = 11'h000;
	localparam logic [AIN_BITS-1:0] PEAK_RESET = 10'h3FF;

	// ----------------------------------------------------------------
	// input conditioning modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		VCX_CLAMP_NONE,
		VCX_CLAMP_PEAK,
		VCX_CLAMP_KEYED
	} vcx_clamp_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [AIN_BITS-1:0] level;
		logic [AIN_BITS-1:0] clamp_level;
		logic key;
	} vcx_ain_t;

	typedef struct packed
	{
		logic [DAC_BITS-1:0] word;
		logic [DAC_BITS-1:0] feed;
		logic use_feed;
	} vcx_dac_in_t;

endpackage : vcx_pkg

// ===== vcx_codec_asserts.sv
module vcx_codec_asserts
(
	// watched ports
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic ADC_CLK,
	input wire logic DAC_CLK,
	input wire vcx_pkg::vcx_ain_t AIN,
	input wire vcx_pkg::vcx_clamp_t CLAMP_MODE,
	input wire vcx_pkg::vcx_dac_in_t DAC_IN,
	input wire logic [7:0] ADC_DATA,
	input wire logic [9:0] DAC_OUT,
	input wire logic DAC_SRC_EXT,
	input wire logic CLAMP_SW
);
	logic [4:0] up;
	logic a_q, d_q, v1, v2, none_q;
	logic [7:0] e1, e2;
	wire ok = up[4];
	wire arise = ADC_CLK && !a_q;
	wire drise = DAC_CLK && !d_q;
	wire keyed = AIN.key && CLAMP_MODE == vcx_pkg::VCX_CLAMP_KEYED;
	function automatic logic [7:0] sat(input logic [9:0] v);
		return (v[9:8] != 2'h0) ? 8'hFF : v[7:0];
	endfunction : sat
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			up <= 5'h00;
			a_q <= 1'h0;
			d_q <= 1'h0;
			v1 <= 1'h0;
			v2 <= 1'h0;
			none_q <= 1'h0;
		end
		else
		begin
			up <= {up[3:0], 1'h1};
			a_q <= ADC_CLK;
			d_q <= DAC_CLK;
			// offset only reads zero once the mode has been none for a cycle
			none_q <= CLAMP_MODE == vcx_pkg::VCX_CLAMP_NONE;
			if (arise)
			begin
				e1 <= keyed ? sat(AIN.clamp_level) : sat(AIN.level);
				v1 <= ok && (keyed || (none_q && CLAMP_MODE == vcx_pkg::VCX_CLAMP_NONE));
				e2 <= e1;
				v2 <= v1;
			end
		end
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	sequence dac_take;
		drise ##1 !DAC_IN.use_feed;
	endsequence
	a_src_select: assert property (ok |-> DAC_SRC_EXT == $past(DAC_IN.use_feed))
		else $error("source flag wrong");
	a_feed_route: assert property (ok && $past(DAC_IN.use_feed) |-> DAC_OUT == $past(DAC_IN.feed))
		else $error("feed not routed");
	a_dac_capture: assert property (ok ##0 dac_take |=> DAC_OUT == $past(DAC_IN.word, 2))
		else $error("word not converted");
	a_dac_hold: assert property (ok && $changed(DAC_OUT) |-> $past(DAC_IN.use_feed)
		|| $past(DAC_IN.use_feed, 2) || $past(drise, 2)) else $error("output moved");
	a_adc_hold: assert property (ok && $changed(ADC_DATA) |-> $past(arise))
		else $error("sample moved off edge");
	a_code_track: assert property (ok && $past(arise) && v2 |-> ADC_DATA == e2)
		else $error("sample code wrong");
	a_sw_close: assert property (ok && keyed |=> CLAMP_SW)
		else $error("clamp switch open");
	a_sw_open: assert property (ok && !keyed |=> !CLAMP_SW)
		else $error("clamp switch closed");
endmodule : vcx_codec_asserts
bind vcx_codec vcx_codec_asserts chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADC_CLK(ADC_CLK),
	.DAC_CLK(DAC_CLK), .AIN(AIN), .CLAMP_MODE(CLAMP_MODE), .DAC_IN(DAC_IN), .ADC_DATA(ADC_DATA),
	.DAC_OUT(DAC_OUT), .DAC_SRC_EXT(DAC_SRC_EXT), .CLAMP_SW(CLAMP_SW));

// ===== vcx_dsp.sv
module vcx_dsp
(
	// clock and start
	input wire logic clk,
	input wire logic run,
	// converter clocks and word
	output logic adc_clk,
	output logic dac_clk,
	output logic [9:0] word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt;
	logic [9:0] w;
	assign adc_clk = run && cnt[1];
	assign dac_clk = run && cnt[2];
	assign word = run ? w : 10'h000;
	always_ff @(posedge clk)
	begin
		if (!run)
		begin
			cnt <= 3'h0;
			w <= 10'h000;
		end
		else
		begin
			cnt <= cnt + 3'h1;
			if (cnt == 3'h1)
				w <= (w + 10'h0B4) & 10'h3FC;
		end
	end
endmodule : vcx_dsp

// ===== video_adc_dac_codec_interface_test.sv
module video_adc_dac_codec_interface_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, rst_n = 1'h0, run = 1'h0, sel = 1'h0, key, adc_clk, dac_clk, src, sw;
	logic [9:0] word, dout, lv, cl, feed = 10'h000;
	logic [7:0] adat;
	logic [31:0] seed = 32'h5FBD0242;
	vcx_pkg::vcx_ain_t ain = '0;
	vcx_pkg::vcx_clamp_t mode = vcx_pkg::VCX_CLAMP_NONE;
	int error_cnt = 0, checks_done = 0;
	logic dq = 1'h0;
	logic [9:0] cap = 10'h000, held = 10'h000;
	// model of the word capture on the converter clock
	always @(posedge clk)
	begin
		dq <= dac_clk;
		if (dac_clk && !dq)
			cap <= word;
		held <= cap;
	end
	vcx_dsp peer (.clk(clk), .run(run), .adc_clk(adc_clk), .dac_clk(dac_clk), .word(word));
	vcx_codec uut (.CORE_CLK(clk), .RST_N(rst_n), .ADC_CLK(adc_clk), .DAC_CLK(dac_clk), .AIN(ain),
		.CLAMP_MODE(mode), .DAC_IN({word, feed, sel}), .ADC_DATA(adat), .DAC_OUT(dout),
		.DAC_SRC_EXT(src), .CLAMP_SW(sw));
	initial forever #4 clk = !clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction : xs
	function automatic logic [7:0] exp_code(input logic [9:0] v);
		return v > 10'h0FF ? 8'hFF : v[7:0];
	endfunction : exp_code
	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		#20000;
		error_cnt++;
		give_verdict();
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		run <= 1'h1;
		for (int i = 0; i < 48; i++)
		begin
			seed = xs(seed);
			lv = i == 0 ? 10'h000 : i == 1 ? 10'h0FF : i == 2 ? 10'h3FF : {1'h0, seed[8:0]};
			cl = {1'h0, seed[18:10]};
			key = i > 2 && i % 3 == 2;
			// key only while input sits at clamp level
			ain <= {key ? cl : lv, cl, key};
			mode <= vcx_pkg::vcx_clamp_t'(i < 3 ? 0 : i % 3);
			sel <= seed[20];
			feed <= seed[30:21];
			repeat (15) @(posedge clk);
			@(negedge clk);
			// peak and keyed clamp both settle on the clamp level
			chk("adc", {2'h0, exp_code(i > 2 && i % 3 ? cl : lv)}, {2'h0, adat});
			chk("src", {9'h000, seed[20]}, {9'h000, src});
			chk("dac", seed[20] ? seed[30:21] : held, dout);
			chk("sw", {9'h000, key}, {9'h000, sw});
			@(posedge clk);
		end
		give_verdict();
	end
endmodule : video_adc_dac_codec_interface_test
